//--- hw/acp_config_port.sv
// Mode configuration port: serial register access, parallel straps, mode outputs
`include "acp_map.svh"
`timescale 1ns/1ns
`default_nettype none
module acp_config_port
  import acp_pkg::*;
#(
  parameter int CHANNELS = 4,
  parameter int DATA_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Programming mode strap
  input wire logic serial_parallel_select,
  // Serial port pins
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_in,
  output logic sdo_out,
  output logic sdo_oe,
  // Converter samples and over-range flags
  input wire logic [CHANNELS*DATA_W-1:0] sample_in,
  input wire logic [CHANNELS-1:0] overrange_in,
  // Formatted words: {Dx, Dy, D11..D0} per channel
  output logic [CHANNELS*(DATA_W+2)-1:0] data_out,
  // Mode controls to the converter
  output logic duty_stabilizer_disable,
  output logic output_scramble_enable,
  output logic signed_format_select,
  output logic sleep_active,
  output logic [CHANNELS-1:0] nap_channel,
  output logic output_drive_disable,
  output logic [2:0] lvds_current_sel,
  output logic term_enable,
  output logic [2:0] output_mode,
  output logic test_pattern_enable
);

  localparam int WW = DATA_W + 2;
  localparam int BW = `ACP_BIT_CNT_W;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; chip select enters inverted so a cleared flop reads idle
  logic [4:0] pins_s;
  logic par_s;
  logic cs_on_s;
  logic sck_s;
  logic sdi_s;
  logic sdo_in_s;
  logic sck_d_reg;

  acp_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .din({serial_parallel_select, !cs_n, sck, sdi, sdo_in}),
    .dout(pins_s)
  );

  assign par_s = pins_s[4];
  assign cs_on_s = pins_s[3];
  assign sck_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign sdo_in_s = pins_s[0];

  always_ff @(posedge clk)
  begin
    if (srst)
      sck_d_reg <= 1'b0;
    else
      sck_d_reg <= sck_s;
  end

  wire serial_mode = !par_s;
  wire sck_rise = sck_s && !sck_d_reg;
  wire sck_fall = !sck_s && sck_d_reg;
  wire cs_act = serial_mode && cs_on_s;

  ////////////////////////////////////////////////////////////////////////////
  // Serial word receiver
  acp_phase_e phase_reg;
  acp_phase_e phase_next;
  logic [BW-1:0] bit_cnt_reg;
  logic [14:0] in_shift_reg;
  logic rd_reg;
  logic [7:0] rd_shift_reg;

  wire take_bit = (phase_reg == ACP_PH_SHIFT) && sck_rise;
  wire last_bit = take_bit && (bit_cnt_reg == `ACP_WORD_BITS - 5'h01);
  wire addr_bit = take_bit && (bit_cnt_reg == `ACP_ADDR_DONE - 5'h01);
  // First captured bit is read/write, then address, then data
  wire word_rd = in_shift_reg[14];
  wire [6:0] word_addr = in_shift_reg[13:7];
  wire [7:0] word_data = {in_shift_reg[6:0], sdi_s};
  wire commit_wr = last_bit && !word_rd;
  wire rd_load = addr_bit && in_shift_reg[6];

  always_comb
  begin
    phase_next = phase_reg;
    unique case (phase_reg)
      ACP_PH_IDLE:
        if (cs_act)
          phase_next = ACP_PH_SHIFT;
      ACP_PH_SHIFT:
        if (!cs_act)
          phase_next = ACP_PH_IDLE;
        else if (last_bit)
          phase_next = ACP_PH_DONE;
      ACP_PH_DONE:
        if (!cs_act)
          phase_next = ACP_PH_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      phase_reg <= ACP_PH_IDLE;
      bit_cnt_reg <= '0;
      in_shift_reg <= '0;
    end
    else
    begin
      phase_reg <= phase_next;
      if (phase_reg == ACP_PH_IDLE)
        bit_cnt_reg <= '0;
      else if (take_bit)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      if (take_bit)
        in_shift_reg <= {in_shift_reg[13:0], sdi_s};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode registers

  logic [7:0] fmt_reg;
  logic [7:0] mode_reg;
  logic [7:0] tp_hi_reg;
  logic [7:0] tp_lo_reg;
  logic soft_rst_reg;

  // Reset register is write-only and reads as zero
  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] f,
                                          input logic [7:0] m, input logic [7:0] h,
                                          input logic [7:0] l);
    logic [7:0] r;
    r = 8'h00;
    unique case (a)
      `ACP_ADDR_FMT: r = f;
      `ACP_ADDR_MODE: r = m;
      `ACP_ADDR_TP_HI: r = h;
      `ACP_ADDR_TP_LO: r = l;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : reg_read

  // Bits 6..0 of the reset register are don't-care
  wire soft_rst_hit = commit_wr && (word_addr == `ACP_ADDR_RESET)
                      && word_data[`ACP_RESET_BIT];

  always_ff @(posedge clk)
  begin
    if (srst || soft_rst_hit)
    begin
      fmt_reg <= `ACP_REG_RST_VAL;
      mode_reg <= `ACP_REG_RST_VAL;
      tp_hi_reg <= `ACP_REG_RST_VAL;
      tp_lo_reg <= `ACP_REG_RST_VAL;
    end
    else if (commit_wr)
    begin
      if (word_addr == `ACP_ADDR_FMT)
        fmt_reg <= word_data;
      if (word_addr == `ACP_ADDR_MODE)
        mode_reg <= word_data;
      if (word_addr == `ACP_ADDR_TP_HI)
        tp_hi_reg <= word_data;
      if (word_addr == `ACP_ADDR_TP_LO)
        tp_lo_reg <= word_data;
    end
  end

  // One-cycle sleep pulse; the reset bit itself is never stored
  always_ff @(posedge clk)
  begin
    if (srst)
      soft_rst_reg <= 1'b0;
    else
      soft_rst_reg <= soft_rst_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-back on SDO; D7 stays over the fall after bit 8 so the host takes it on rise 9
  always_ff @(posedge clk)
  begin
    if (srst || !cs_act)
    begin
      rd_reg <= 1'b0;
      rd_shift_reg <= 8'hFF;
    end
    else if (rd_load)
    begin
      rd_reg <= 1'b1;
      rd_shift_reg <= reg_read({in_shift_reg[5:0], sdi_s}, fmt_reg, mode_reg,
                               tp_hi_reg, tp_lo_reg);
    end
    else if (rd_reg && sck_fall && phase_reg == ACP_PH_SHIFT && bit_cnt_reg != `ACP_ADDR_DONE)
      rd_shift_reg <= {rd_shift_reg[6:0], 1'b1};
  end

  // Open drain; gated by chip select so the pin holds the last bit after the word and lets go once chip select rises
  assign sdo_out = 1'b0;
  assign sdo_oe = cs_act && rd_reg && !rd_shift_reg[7];

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs, serial registers or parallel straps
  wire strap_cs = !cs_on_s;
  wire strap_sleep = par_s && sdi_s;
  wire reg_sleep = serial_mode && fmt_reg[`ACP_FMT_SLEEP];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      duty_stabilizer_disable <= 1'b0;
      output_scramble_enable <= 1'b0;
      signed_format_select <= 1'b0;
      sleep_active <= 1'b0;
      nap_channel <= '0;
      output_drive_disable <= 1'b0;
      lvds_current_sel <= `ACP_CUR_3M5;
      term_enable <= 1'b0;
      output_mode <= `ACP_OM_2L16;
      test_pattern_enable <= 1'b0;
    end
    else if (par_s)
    begin
      duty_stabilizer_disable <= 1'b0;
      output_scramble_enable <= 1'b0;
      signed_format_select <= 1'b0;
      sleep_active <= strap_sleep;
      nap_channel <= '0;
      output_drive_disable <= 1'b0;
      lvds_current_sel <= sck_s ? `ACP_CUR_1M75 : `ACP_CUR_3M5;
      term_enable <= sdo_in_s;
      output_mode <= strap_cs ? `ACP_OM_1L14 : `ACP_OM_2L16;
      test_pattern_enable <= 1'b0;
    end
    else
    begin
      duty_stabilizer_disable <= fmt_reg[`ACP_FMT_DCS_OFF];
      output_scramble_enable <= fmt_reg[`ACP_FMT_SCRAMBLE];
      signed_format_select <= fmt_reg[`ACP_FMT_SIGNED];
      sleep_active <= reg_sleep || soft_rst_reg;
      nap_channel <= reg_sleep ? '0 : fmt_reg[CHANNELS-1:0];
      output_drive_disable <= mode_reg[`ACP_MODE_OUTPUT_DRIVE_DISABLE];
      lvds_current_sel <= mode_reg[`ACP_MODE_CUR_HI:`ACP_MODE_CUR_LO];
      term_enable <= mode_reg[`ACP_MODE_TERM];
      output_mode <= mode_reg[`ACP_MODE_OM_HI:0];
      test_pattern_enable <= tp_hi_reg[`ACP_TP_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output data formatting
  wire [WW-1:0] pattern = {tp_hi_reg[`ACP_TP_HI_MSB:0], tp_lo_reg};

  // Offset binary to two's complement, then LSB-xor randomizing
  function automatic logic [WW-1:0] fmt_word(input logic [DATA_W-1:0] s,
                                             input logic ovr, input logic sgn,
                                             input logic scr);
    logic [DATA_W-1:0] d;
    d = sgn ? {~s[DATA_W-1], s[DATA_W-2:0]} : s;
    if (scr)
      d = {d[DATA_W-1:1] ^ {(DATA_W-1){d[0]}}, d[0]};
    return {ovr, ovr, d};
  endfunction : fmt_word

  always_ff @(posedge clk)
  begin
    if (srst)
      data_out <= '0;
    else
      for (int c = 0; c < CHANNELS; c++)
        data_out[c*WW +: WW] <= test_pattern_enable ? pattern
          : fmt_word(sample_in[c*DATA_W +: DATA_W], overrange_in[c],
                     signed_format_select, output_scramble_enable);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_write_fmt;
    commit_wr && word_addr == `ACP_ADDR_FMT && phase_reg == ACP_PH_SHIFT;
  endsequence
  sequence s_read_word;
    last_bit && word_rd;
  endsequence
  AST_WRITE_STORES: assert property (s_write_fmt |=> fmt_reg == $past(word_data))
    else $error("format register missed a serial write");
  AST_READ_NO_UPDATE: assert property (s_read_word |=> $stable(fmt_reg) && $stable(mode_reg))
    else $error("read command changed a register");
  AST_EXTRA_EDGES: assert property (phase_reg == ACP_PH_DONE && sck_rise
                                    |=> $stable(in_shift_reg) && $stable(bit_cnt_reg))
    else $error("rising edge after bit 16 was captured");
  AST_SOFT_RESET: assert property (soft_rst_hit |=> fmt_reg == 8'h00 && mode_reg == 8'h00
                                   && tp_hi_reg == 8'h00 && tp_lo_reg == 8'h00 ##1 sleep_active)
    else $error("software reset did not clear and pulse sleep");
  AST_RESET_WO: assert property (rd_load && {in_shift_reg[5:0], sdi_s} == `ACP_ADDR_RESET
                                 |=> rd_shift_reg == 8'h00)
    else $error("reset register read back nonzero");
  AST_SDO_PULL_LOW: assert property (sdo_oe |-> rd_reg && sdo_out == 1'b0 && cs_act)
    else $error("SDO driven outside a read or driven high");
  AST_TEST_PATTERN: assert property (test_pattern_enable |=> data_out[WW-1:0] == $past(pattern))
    else $error("test pattern not forced on channel 1");
  AST_OUTPUT_OFF: assert property (serial_mode && $stable(par_s) && mode_reg[`ACP_MODE_OUTPUT_DRIVE_DISABLE]
                                   |=> output_drive_disable)
    else $error("output disable not applied");
  AST_PAR_SLEEP: assert property (par_s && sdi_s |=> sleep_active)
    else $error("parallel sleep strap ignored");
  AST_PAR_LANES: assert property (par_s && !cs_on_s |=> output_mode == `ACP_OM_1L14)
    else $error("parallel lane strap ignored");
  AST_NAP: assert property (serial_mode && !fmt_reg[`ACP_FMT_SLEEP]
                            |=> nap_channel == $past(fmt_reg[CHANNELS-1:0]))
    else $error("nap channels do not follow register");

endmodule : acp_config_port
`default_nettype wire

//--- hw/acp_map.svh
// Register offsets, field positions and coding constants of the config port
`ifndef ACP_MAP_SVH
`define ACP_MAP_SVH

`define ACP_ADDR_RESET 7'h00
`define ACP_ADDR_FMT 7'h01
`define ACP_ADDR_MODE 7'h02
`define ACP_ADDR_TP_HI 7'h03
`define ACP_ADDR_TP_LO 7'h04

`define ACP_REG_RST_VAL 8'h00
`define ACP_RESET_BIT 7

`define ACP_FMT_DCS_OFF 7
`define ACP_FMT_SCRAMBLE 6
`define ACP_FMT_SIGNED 5
`define ACP_FMT_SLEEP 4
`define ACP_FMT_NAP_HI 3

`define ACP_MODE_CUR_HI 7
`define ACP_MODE_CUR_LO 5
`define ACP_MODE_TERM 4
`define ACP_MODE_OUTPUT_DRIVE_DISABLE 3
`define ACP_MODE_OM_HI 2

`define ACP_TP_EN_BIT 7
`define ACP_TP_HI_MSB 5

`define ACP_BIT_CNT_W 5
`define ACP_WORD_BITS 5'h10
`define ACP_ADDR_DONE 5'h08

`define ACP_OM_2L16 3'h0
`define ACP_OM_1L14 3'h5
`define ACP_CUR_3M5 3'h0
`define ACP_CUR_1M75 3'h7

`endif

//--- hw/acp_pkg.sv
// Types shared by the config port design
package acp_pkg;
  typedef enum logic [2:0] {
    ACP_PH_IDLE = 3'b001,
    ACP_PH_SHIFT = 3'b010,
    ACP_PH_DONE = 3'b100
  } acp_phase_e;
endpackage : acp_pkg

//--- hw/acp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module acp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Async in, synced out
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule : acp_sync
`default_nettype wire

//--- sim/acp_config_port_tb.sv
// Self-checking bench of the configuration port
`timescale 1ns/1ns
`default_nettype none
module acp_config_port_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sps = 1'b0;
  logic [47:0] samp = 48'h801_7FF_000_ABC;
  logic [3:0] ovr = 4'h2;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  // References are not modelled, so the wake-up wait is cut to the nap minimum
  localparam int WAKE_CYCLES = 100;
  wire logic cs_n, sck, sdi, sdo_pull, sdo_out, sdo_oe, sdo_wire;
  wire logic [55:0] dout;
  wire logic [16:0] st;
  wire logic dsd, scr, sgn, slp, odd, term, tpe;
  wire logic [3:0] nap;
  wire logic [2:0] cur, om;

  always #5 clk = ~clk;
  // Pull-up unless the device pulls low
  assign sdo_wire = sdo_oe ? sdo_out : sdo_pull;
  assign st = {dsd, scr, sgn, slp, nap, odd, cur, term, om, tpe};

  acp_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_pull(sdo_pull), .sdo_wire(sdo_wire));

  acp_config_port #(.CHANNELS(4), .DATA_W(12)) uut (
    .clk(clk), .srst(srst), .serial_parallel_select(sps), .cs_n(cs_n), .sck(sck), .sdi(sdi),
    .sdo_in(sdo_wire), .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sample_in(samp), .overrange_in(ovr),
    .data_out(dout), .duty_stabilizer_disable(dsd), .output_scramble_enable(scr),
    .signed_format_select(sgn), .sleep_active(slp), .nap_channel(nap), .output_drive_disable(odd),
    .lvds_current_sel(cur), .term_enable(term), .output_mode(om), .test_pattern_enable(tpe));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n = 16);
    logic [7:0] r;
    host.xfer({1'b0, a, d}, n, r);
    repeat (4) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] r;
    // Data bits all ones: a read must not store them
    host.xfer({1'b1, a, 8'hFF}, 16, r);
    chk(r, exp);
  endtask : rd

  // Expected mode outputs from format, output mode and pattern MSB registers
  function automatic logic [16:0] exp_st(input logic [7:0] f, input logic [7:0] m, input logic [7:0] t);
    return {f[7:4], f[4] ? 4'h0 : f[3:0], m[3], m[7:5], m[4], m[2:0], t[7]};
  endfunction : exp_st

  function automatic logic [13:0] fmt_word(input logic [11:0] s, input logic o, input logic [7:0] f);
    logic [11:0] v;
    v = f[5] ? s ^ 12'h800 : s;
    if (f[6])
      v[11:1] = v[11:1] ^ {11{v[0]}};
    return {o, o, v};
  endfunction : fmt_word

  task automatic chk_data(input logic [7:0] f);
    for (int c = 0; c < 4; c++)
      chk(dout[c*14+:14], fmt_word(samp[c*12+:12], ovr[c], f));
  endtask : chk_data
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    // Nearly four times the expected run
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    chk(st, 17'h0);
    wr(7'h00, 8'h80);
    chk(st, exp_st(8'h00, 8'h00, 8'h00));
    for (int k = 0; k < 4; k++)
    begin
      wr(7'h01, 8'(k * 32));
      chk(st, exp_st(8'(k * 32), 8'h00, 8'h00));
      chk_data(8'(k * 32));
    end
    wr(7'h01, 8'hE5);
    chk(st, exp_st(8'hE5, 8'h00, 8'h00));
    rd(7'h01, 8'hE5);
    wr(7'h01, 8'h1F);
    chk(st, exp_st(8'h1F, 8'h00, 8'h00));
    wr(7'h02, 8'hE8);
    chk(st, exp_st(8'h1F, 8'hE8, 8'h00));
    rd(7'h02, 8'hE8);
    rd(7'h02, 8'hE8);
    rd(7'h00, 8'h00);
    wr(7'h00, 8'h7F);
    chk(st, exp_st(8'h1F, 8'hE8, 8'h00));
    wr(7'h01, 8'h40, 20);
    chk(st, exp_st(8'h40, 8'hE8, 8'h00));
    repeat (WAKE_CYCLES) @(negedge clk);
    chk_data(8'h40);
    wr(7'h01, 8'h00, 12);
    chk(st, exp_st(8'h40, 8'hE8, 8'h00));
    wr(7'h03, 8'hAA);
    wr(7'h04, 8'h5C);
    chk(st, exp_st(8'h40, 8'hE8, 8'hAA));
    for (int c = 0; c < 4; c++)
      chk(dout[c*14+:14], 14'h2A5C);
    wr(7'h00, 8'h80);
    chk(st, 17'h0);
    rd(7'h02, 8'h00);
    sps = 1'b1;
    host.strap(4'hF);
    repeat (10) @(negedge clk);
    chk(st, {4'b0001, 4'h0, 1'b0, 3'h7, 1'b1, 3'h5, 1'b0});
    host.strap(4'h0);
    repeat (10) @(negedge clk);
    chk(st, 17'h0);
    complete_run();
  end
endmodule : acp_config_port_tb
`default_nettype wire

//--- sim/acp_host_model.sv
// Host side model driving the serial configuration pins
`timescale 1ns/1ns
`default_nettype none
module acp_host_model (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic cs_n,
  output logic sck,
  output logic sdi,
  output logic sdo_pull,
  input wire logic sdo_wire
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    sdo_pull = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One word MSB first; n below 16 gives a short word, above 16 extra rises
  task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
    logic [15:0] sh;
    sh = w;
    rd = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      sdi = sh[15];
      sh = {sh[14:0], 1'b1};
      repeat (8) @(negedge clk);
      sck = 1'b1;
      rd = {rd[6:0], sdo_wire};
      repeat (8) @(negedge clk);
      sck = 1'b0;
    end
    repeat (8) @(negedge clk);
    cs_n = 1'b1;
    // Released line must not look like held data
    sdi = ~sdi;
    repeat (8) @(negedge clk);
  endtask : xfer
  ////////////////////////////////////////////////////////////////////////////////
  // Parallel mode straps: cs_n, sck, sdi, sdo
  task automatic strap(input logic [3:0] v);
    {cs_n, sck, sdi, sdo_pull} = v;
  endtask : strap
endmodule : acp_host_model
`default_nettype wire
